// *** verilog/tdl_link.sv ***
// Overhead data link block with its transmit bit FIFO.
`timescale 1ns/1ps
// Notes on behaviour
// - E1 link uses spare bits four to eight
// - Select field bit one includes that spare bit
// - E1 transmit clock pulses 244 ns nominal, 24 cycles (240 ns) here
// - E1 transmit clock only in bit times 4..0
// - Link data captured at transmit clock rise
// - Selected spare bits override other functions
// - E1 receive data out at line rate
// - Receive clock pulses only at selected bits
// - Frame slips never drop or repeat link bits
// - T1 external pins when link control bit 7
// - T1 link clocks run at 4 kHz
// - Fs bit in SLC-96, odd FACILITY_LINK_BITS in ESF
// - Bit 6 sends flag then message byte repeatedly
// - Message loaded after 7 of last 10
// - New message interrupts unless mask bit low
// - Message pause once per second, 100 ms max
// - Controller zero on FACILITY_LINK_BITS at channel 31
// - Controller zero at timeslot zero: spare bits

// ==========================================================
// Small FIFO with valid/ready on both sides
module tdl_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
	logic [AW-1:0] wr_ptr_reg; // Write slot
	logic [AW-1:0] rd_ptr_reg; // Read slot
	logic [AW:0] count_reg; // Words held
	logic push;
	logic pop;
	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end
	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==========================================================
// Overhead data link top
module tdl_link #(
	parameter int SEC_COUNT = tdl_pkg::SEC_CYC, // One second
	parameter int PAUSE_COUNT = tdl_pkg::PAUSE_CYC, // Longest pause
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [4:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	input wire logic e1_mode,
	input wire logic t1_esf,
	input wire tdl_pkg::tdl_frame_t tx_frame,
	input wire tdl_pkg::tdl_bp_t tx_bp,
	input wire tdl_pkg::tdl_frame_t rx_frame,
	output tdl_pkg::tdl_oh_t tx_oh,
	output logic tx_link_clock,
	input wire logic tx_link_data,
	output logic rx_link_clock,
	output logic rx_link_data,
	output logic msg_irq,
	input wire logic [4:0] hdlc_controller_zero_channel,
	input wire logic hdlc_controller_zero_tx_bit,
	output logic hdlc_controller_zero_tx_strobe,
	output logic hdlc_controller_zero_rx_strobe,
	output logic hdlc_controller_zero_rx_bit
);
	import tdl_pkg::*;

	// ==========================================================
	// Register port: page select then register within the page
	logic [7:0] page_reg; // Selected page
	logic [7:0] link_ctrl_reg; // Link control word
	logic [7:0] tx_msg_reg; // Transmit message byte
	logic [7:0] rx_msg_reg; // Last validated message
	logic [7:0] spare_sel_reg; // Spare bit selection
	logic [7:0] irq_mask3_reg; // Interrupt mask word three

	// Decodes one register of one page
	function automatic logic hit(input logic [4:0] a, input logic [7:0] pg,
		input logic [4:0] ra, input logic [7:0] rp);
		hit = a[CAR_SEL_BIT] && (a[3:0] == ra[3:0]) && (pg == rp);
	endfunction

	// Writable registers, all cleared by reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			page_reg <= REG_RESET;
			link_ctrl_reg <= REG_RESET;
			tx_msg_reg <= REG_RESET;
			spare_sel_reg <= REG_RESET;
			irq_mask3_reg <= REG_RESET;
		end else if (cpu_wr) begin
			if (!cpu_addr[CAR_SEL_BIT]) begin
				page_reg <= cpu_wdata;
			end
			if (hit(cpu_addr, page_reg, ADDR_LINK_CTRL, PAGE_CTRL)) begin
				link_ctrl_reg <= cpu_wdata;
			end
			if (hit(cpu_addr, page_reg, ADDR_TX_MSG, PAGE_CTRL)) begin
				tx_msg_reg <= cpu_wdata;
			end
			if (hit(cpu_addr, page_reg, ADDR_SPARE_SEL, PAGE_CTRL)) begin
				spare_sel_reg <= cpu_wdata;
			end
			if (hit(cpu_addr, page_reg, ADDR_IRQ_MASK3, PAGE_CTRL)) begin
				irq_mask3_reg <= cpu_wdata;
			end
		end
	end

	// Read data registered; unmapped reads return zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpu_rdata <= REG_RESET;
		end else if (cpu_rd) begin
			if (!cpu_addr[CAR_SEL_BIT]) begin
				cpu_rdata <= page_reg;
			end else if (hit(cpu_addr, page_reg, ADDR_LINK_CTRL, PAGE_CTRL)) begin
				cpu_rdata <= link_ctrl_reg;
			end else if (hit(cpu_addr, page_reg, ADDR_TX_MSG, PAGE_CTRL)) begin
				cpu_rdata <= tx_msg_reg;
			end else if (hit(cpu_addr, page_reg, ADDR_SPARE_SEL, PAGE_CTRL)) begin
				cpu_rdata <= spare_sel_reg;
			end else if (hit(cpu_addr, page_reg, ADDR_IRQ_MASK3, PAGE_CTRL)) begin
				cpu_rdata <= irq_mask3_reg;
			end else if (hit(cpu_addr, page_reg, ADDR_RX_MSG, PAGE_STAT)) begin
				cpu_rdata <= rx_msg_reg;
			end else begin
				cpu_rdata <= REG_RESET;
			end
		end
	end

	// ==========================================================
	// Path selection
	logic ext_en; // External pins own the T1 link
	logic msg_en; // Bit messages own the T1 link
	logic hdlc_fdl; // Controller zero on facility bits
	logic hdlc_ts0; // Controller zero on timeslot zero
	logic tx_sa_sel; // Current tx spare bit is a link bit
	logic rx_sa_sel; // Current rx spare bit is a link bit
	logic tx_t1_slot; // Current tx overhead link slot
	logic rx_t1_slot; // Current rx overhead link slot
	assign ext_en = link_ctrl_reg[BIT_EXT_LINK];
	assign msg_en = link_ctrl_reg[BIT_MSG_EN];
	assign hdlc_fdl = !e1_mode && t1_esf && (hdlc_controller_zero_channel == HDLC_FDL_CH);
	assign hdlc_ts0 = e1_mode && (hdlc_controller_zero_channel == HDLC_TS0_CH);
	// Index 0..4 maps to spare bits four to eight
	assign tx_sa_sel = e1_mode && tx_frame.sa_strobe && (tx_frame.sa_index < 3'h5)
		&& spare_sel_reg[tx_frame.sa_index];
	assign rx_sa_sel = e1_mode && rx_frame.sa_strobe && (rx_frame.sa_index < 3'h5)
		&& spare_sel_reg[rx_frame.sa_index];
	// Fs slot in SLC-96, odd-frame facility bits in ESF
	assign tx_t1_slot = !e1_mode && (t1_esf ? tx_frame.fdl_strobe
		: tx_frame.fs_strobe);
	assign rx_t1_slot = !e1_mode && (t1_esf ? rx_frame.fdl_strobe
		: rx_frame.fs_strobe);

	// ==========================================================
	// Transmit pin side: clock pulse, synchroniser, capture
	logic [1:0] txd_sync_reg; // Pin synchroniser, [0] is first stage
	logic [4:0] tx_pulse_reg; // Cycles left in clock pulse
	logic tx_pulse_start;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_data;
	logic fifo_out_valid;
	logic fifo_pop;
	logic tx_pins_active; // External pins in use for transmit
	assign tx_pins_active = e1_mode ? !hdlc_ts0 : (ext_en && !hdlc_fdl);
	// Only ask for a bit when the FIFO can take it, so the pin clock
	// averages out at the link bit rate
	assign tx_pulse_start = tx_pins_active && fifo_in_ready && (tx_pulse_reg == '0)
		&& (e1_mode ? (tx_bp.strobe && tx_bp.index <= 3'h4)
		: tx_t1_slot);
	assign tx_link_clock = (tx_pulse_reg != '0);
	// Sampling two cycles into the pulse sees the pin as it stood at the rise
	assign fifo_in_valid = (tx_pulse_reg == 5'(TX_CAPTURE_AT));

	// Pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txd_sync_reg <= 2'h0;
		end else begin
			txd_sync_reg <= {txd_sync_reg[0], tx_link_data};
		end
	end

	// Transmit clock pulse width
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_pulse_reg <= '0;
		end else if (tx_pulse_start) begin
			tx_pulse_reg <= 5'(PULSE_CYC);
		end else if (tx_pulse_reg != '0) begin
			tx_pulse_reg <= tx_pulse_reg - 5'h1;
		end
	end

	tdl_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_data(txd_sync_reg[1]),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	// ==========================================================
	// Bit message transmitter and its pause budget
	logic [3:0] msg_idx_reg; // Bit position within flag+byte
	logic [15:0] msg_word;
	logic [$clog2(SEC_COUNT+1)-1:0] sec_cnt_reg; // One second window
	logic [$clog2(PAUSE_COUNT+1)-1:0] pause_cnt_reg; // Pause spent
	logic paused_reg; // Pause in progress
	logic pause_used_reg; // Pause already taken this second
	logic pause_ok;
	assign msg_word = {MSG_FLAG, tx_msg_reg};
	// A pause may start once per second and never outlasts its limit
	assign pause_ok = hdlc_fdl && msg_en
		&& (paused_reg || !pause_used_reg)
		&& (pause_cnt_reg < $bits(pause_cnt_reg)'(PAUSE_COUNT));

	// Pause bookkeeping
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sec_cnt_reg <= '0;
			pause_cnt_reg <= '0;
			paused_reg <= 1'b0;
			pause_used_reg <= 1'b0;
		end else begin
			paused_reg <= pause_ok;
			if (sec_cnt_reg == $bits(sec_cnt_reg)'(SEC_COUNT - 1)) begin
				sec_cnt_reg <= '0;
				pause_used_reg <= pause_ok; // Ongoing pause still counts
				// A pause that spans the boundary keeps its spent budget,
				// otherwise it could run to twice the limit
				pause_cnt_reg <= pause_ok ? pause_cnt_reg + 1'b1 : '0;
			end else begin
				sec_cnt_reg <= sec_cnt_reg + 1'b1;
				if (pause_ok) begin
					pause_used_reg <= 1'b1;
					pause_cnt_reg <= pause_cnt_reg + 1'b1;
				end
			end
		end
	end

	// Message bit position, restarts at the flag when disabled
	always_ff @(posedge clk_sys) begin
		if (reset || !msg_en) begin
			msg_idx_reg <= '0;
		end else if (tx_t1_slot && !(ext_en && !hdlc_fdl)
			&& !hdlc_controller_zero_tx_strobe) begin
			msg_idx_reg <= msg_idx_reg + 4'h1;
		end
	end

	// ==========================================================
	// Transmit overhead multiplexer
	logic tx_link_slot;
	assign tx_link_slot = tx_sa_sel || tx_t1_slot;
	assign fifo_pop = tx_link_slot && tx_pins_active
		&& (e1_mode || ext_en);
	assign hdlc_controller_zero_tx_strobe = (tx_sa_sel && hdlc_ts0)
		|| (tx_t1_slot && hdlc_fdl && !ext_en && (!msg_en || pause_ok));

	// Data out flopped; owner priority: controller, pins, messages, but in T1 the pins and the controller each block the other
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_oh <= '0;
		end else if (tx_sa_sel) begin
			tx_oh.use_bit <= 1'b1;
			tx_oh.value <= hdlc_ts0 ? hdlc_controller_zero_tx_bit
				: (fifo_out_valid ? fifo_out_data : 1'b1);
		end else if (tx_t1_slot && ext_en && !hdlc_fdl) begin
			tx_oh.use_bit <= 1'b1;
			tx_oh.value <= fifo_out_valid ? fifo_out_data : 1'b1;
		end else if (hdlc_controller_zero_tx_strobe) begin
			tx_oh.use_bit <= 1'b1;
			tx_oh.value <= hdlc_controller_zero_tx_bit;
		end else if (tx_t1_slot && msg_en) begin
			tx_oh.use_bit <= 1'b1;
			tx_oh.value <= msg_word[4'hf - msg_idx_reg];
		end else if (tx_frame.bit_strobe) begin
			tx_oh.use_bit <= 1'b0;
			tx_oh.value <= 1'b1;
		end
	end

	// ==========================================================
	// Receive pins: bits are taken before the slip buffer, so a slip
	// never repeats or loses one
	logic [4:0] rx_pulse_reg; // Cycles left in receive pulse
	logic rx_pin_bit; // Current bit belongs on the pins
	assign rx_pin_bit = e1_mode ? (rx_sa_sel && !hdlc_ts0)
		: (rx_t1_slot && ext_en && !hdlc_fdl);
	assign rx_link_clock = (rx_pulse_reg != '0);

	// Receive data and clock pulse, aligned
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_link_data <= 1'b1;
			rx_pulse_reg <= '0;
		end else begin
			if ((e1_mode && rx_frame.bit_strobe) || rx_pin_bit) begin
				rx_link_data <= rx_frame.line_bit;
			end
			if (rx_pin_bit) begin
				rx_pulse_reg <= 5'(PULSE_CYC);
			end else if (rx_pulse_reg != '0) begin
				rx_pulse_reg <= rx_pulse_reg - 5'h1;
			end
		end
	end

	// Controller zero receive feed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hdlc_controller_zero_rx_strobe <= 1'b0;
			hdlc_controller_zero_rx_bit <= 1'b1;
		end else begin
			hdlc_controller_zero_rx_strobe <= (rx_sa_sel && hdlc_ts0) || (rx_t1_slot && hdlc_fdl);
			hdlc_controller_zero_rx_bit <= rx_frame.line_bit;
		end
	end

	// ==========================================================
	// Bit message receiver with 7-of-10 validation
	logic [15:0] rx_shift_reg; // Recent overhead bits
	logic [15:0] rx_shift_next;
	logic [7:0] hist_reg [HIST_LEN-1]; // Previous candidates
	logic [3:0] hist_fill_reg; // Candidates seen so far
	logic cand;
	logic [3:0] agree;
	logic load_msg;
	assign rx_shift_next = {rx_shift_reg[14:0], rx_frame.line_bit};
	assign cand = rx_t1_slot && (rx_shift_next[15:8] == MSG_FLAG)
		&& !rx_shift_next[7] && !rx_shift_next[0];

	// Count agreement of the newest byte over the last ten positions
	always_comb begin
		agree = 4'h1;
		for (int i = 0; i < HIST_LEN - 1; i++) begin
			if (4'(i) < hist_fill_reg && hist_reg[i] == rx_shift_next[7:0]) begin
				agree = agree + 4'h1;
			end
		end
	end
	assign load_msg = cand && (agree >= 4'(HIST_NEED))
		&& (rx_shift_next[7:0] != rx_msg_reg);

	// Shift register and candidate history
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_shift_reg <= '0;
			hist_fill_reg <= '0;
		end else if (rx_t1_slot) begin
			rx_shift_reg <= rx_shift_next;
			if (cand) begin
				hist_reg[0] <= rx_shift_next[7:0];
				for (int i = 1; i < HIST_LEN - 1; i++) begin
					hist_reg[i] <= hist_reg[i-1];
				end
				if (hist_fill_reg < 4'(HIST_LEN - 1)) begin
					hist_fill_reg <= hist_fill_reg + 4'h1;
				end
			end
		end
	end

	// Receive message register keeps the last valid message
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_msg_reg <= REG_RESET;
			msg_irq <= 1'b0;
		end else begin
			if (load_msg) begin
				rx_msg_reg <= rx_shift_next[7:0];
			end
			msg_irq <= load_msg && irq_mask3_reg[BIT_MSG_MASK];
		end
	end

	// ==========================================================
	// Assertions
	property p_tx_pulse_width;
		@(posedge clk_sys) disable iff (reset)
		$rose(tx_link_clock) |-> tx_link_clock [*8] ##16 tx_link_clock ##1 !tx_link_clock;
	endproperty
	a_tx_pulse_width: assert property (p_tx_pulse_width) else $error("tx clock width");
	property p_tx_bit_time;
		@(posedge clk_sys) disable iff (reset)
		$rose(tx_link_clock) && e1_mode |-> $past(tx_bp.strobe) && $past(tx_bp.index) <= 3'h4;
	endproperty
	a_tx_bit_time: assert property (p_tx_bit_time) else $error("tx clock outside bits");
	property p_rx_pulse_sel;
		@(posedge clk_sys) disable iff (reset)
		$rose(rx_link_clock) && e1_mode |-> $past(rx_sa_sel) && !$past(hdlc_ts0);
	endproperty
	a_rx_pulse_sel: assert property (p_rx_pulse_sel) else $error("rx clock not on link bit");
	property p_override;
		@(posedge clk_sys) disable iff (reset)
		tx_sa_sel |=> tx_oh.use_bit;
	endproperty
	a_override: assert property (p_override) else $error("spare bit not overridden");
	property p_capture;
		@(posedge clk_sys) disable iff (reset)
		$rose(tx_link_clock) ##2 1'b1 |-> fifo_in_valid && $past(tx_link_data, 2) == txd_sync_reg[1];
	endproperty
	a_capture: assert property (p_capture) else $error("capture not at rise");
	property p_msg_keep;
		@(posedge clk_sys) disable iff (reset)
		!load_msg |=> $stable(rx_msg_reg);
	endproperty
	a_msg_keep: assert property (p_msg_keep) else $error("message changed unvalidated");
	property p_irq_mask;
		@(posedge clk_sys) disable iff (reset)
		msg_irq |-> $past(load_msg) && $past(irq_mask3_reg[BIT_MSG_MASK]);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("bad message interrupt");
	property p_irq_new;
		@(posedge clk_sys) disable iff (reset)
		load_msg && irq_mask3_reg[BIT_MSG_MASK] |=> msg_irq && rx_msg_reg != $past(rx_msg_reg);
	endproperty
	a_irq_new: assert property (p_irq_new) else $error("missing interrupt");
	// Length of the current pause, kept apart from the budget counter
	logic [$clog2(PAUSE_COUNT+2)-1:0] pause_run_reg;
	always_ff @(posedge clk_sys) begin
		if (reset || !pause_ok) begin
			pause_run_reg <= '0;
		end else begin
			pause_run_reg <= pause_run_reg + 1'b1;
		end
	end
	property p_pause_limit;
		@(posedge clk_sys) disable iff (reset)
		pause_ok |-> pause_run_reg < $bits(pause_run_reg)'(PAUSE_COUNT);
	endproperty
	a_pause_limit: assert property (p_pause_limit) else $error("pause too long");
	property p_idle_oh;
		@(posedge clk_sys) disable iff (reset)
		tx_t1_slot && !ext_en && !msg_en && !hdlc_fdl |=> !tx_oh.use_bit;
	endproperty
	a_idle_oh: assert property (p_idle_oh) else $error("overhead taken while idle");
	c_tx_pulse: cover property (@(posedge clk_sys) disable iff (reset) $rose(tx_link_clock));
	c_rx_pulse: cover property (@(posedge clk_sys) disable iff (reset) $rose(rx_link_clock));
	c_msg_load: cover property (@(posedge clk_sys) disable iff (reset) load_msg);
	c_pause: cover property (@(posedge clk_sys) disable iff (reset) $rose(paused_reg));
endmodule

// *** verilog/tdl_pkg.sv ***
// Shared constants and carrier types for the trunk overhead data link.
package tdl_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] PAGE_CTRL = 8'h01; // Master control page
	localparam logic [7:0] PAGE_STAT = 8'h03; // Master status page
	localparam logic [4:0] ADDR_LINK_CTRL = 5'h12;
	localparam logic [4:0] ADDR_TX_MSG = 5'h13;
	localparam logic [4:0] ADDR_RX_MSG = 5'h15;
	localparam logic [4:0] ADDR_SPARE_SEL = 5'h17;
	localparam logic [4:0] ADDR_IRQ_MASK3 = 5'h1e;
	localparam int CAR_SEL_BIT = 4; // Address bit 4 low selects the page
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================================
	// Field positions
	localparam int BIT_EXT_LINK = 7; // External link enable
	localparam int BIT_MSG_EN = 6; // Bit message enable
	localparam int BIT_MSG_MASK = 1; // Interrupt mask word three
	localparam int SPARE_W = 5; // Spare bits four to eight
	// ==========================================================
	// Message framing and validation
	localparam logic [7:0] MSG_FLAG = 8'hfe;
	localparam int MSG_BITS = 16;
	localparam int HIST_LEN = 10;
	localparam int HIST_NEED = 7;
	// ==========================================================
	// Controller zero attachment
	localparam logic [4:0] HDLC_FDL_CH = 5'h1f; // Phantom channel 31
	localparam logic [4:0] HDLC_TS0_CH = 5'h00;
	// ==========================================================
	// Timing
	localparam int CLK_NS = 10;
	localparam int PULSE_NS = 244;
	localparam int PULSE_CYC = PULSE_NS / CLK_NS; // Nominal width
	localparam int SEC_MS = 1000;
	localparam int PAUSE_MS = 100;
	localparam int CYC_PER_MS = 1000000 / CLK_NS;
	localparam int SEC_CYC = SEC_MS * CYC_PER_MS;
	localparam int PAUSE_CYC = PAUSE_MS * CYC_PER_MS;
	localparam int TX_CAPTURE_AT = PULSE_CYC - 2; // After pin sync
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic sa_strobe; // One spare bit slot of a non-alignment word
		logic [2:0] sa_index; // 0..4 for spare bits four to eight
		logic fs_strobe; // Signaling frame bit slot
		logic fdl_strobe; // Facility link bit slot (odd frames)
		logic bit_strobe; // Any line bit time
		logic line_bit; // Received decoded bit at this strobe
	} tdl_frame_t;
	typedef struct packed {
		logic strobe; // One backplane bit time
		logic [2:0] index; // Bit number 7..0 within the channel
	} tdl_bp_t;
	typedef struct packed {
		logic use_bit; // Link owns this overhead position
		logic value; // Bit to transmit there
	} tdl_oh_t;
endpackage

// *** sim/tdl_far_ctrl.sv ***
// Far-end serial link controller model for the bench.
`timescale 1ns/1ps
module tdl_far_ctrl #(
	parameter logic [15:0] PAT = 16'hb38d
) (
	input wire logic tx_link_clock,
	output logic tx_link_data,
	input wire logic rx_link_clock,
	input wire logic rx_link_data,
	output logic [7:0] rx_bits
);
	// ====
	// Transmit: PAT bits MSB first, one per clock pulse
	int rises = 0; // Capture edges seen
	int sent = 0; // Bits already taken
	always @(posedge tx_link_clock) rises <= rises + 1;
	// Advance at the fall so data holds across the capture edge
	always @(negedge tx_link_clock) sent <= rises;
	assign tx_link_data = PAT[15 - (sent % 16)];
	// ====
	// Receive: shift in at each clock fall; the rise shares its edge
	// with the data update, while the data stands over the whole pulse
	always @(negedge rx_link_clock) rx_bits <= {rx_bits[6:0], rx_link_data};
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the overhead data link block.
`timescale 1ns/1ps
module tb;
	import tdl_pkg::*;
	// ====
	// Stimulus and observed signals
	logic clk_sys = 0, reset = 1, cpu_wr = 0, cpu_rd = 0, e1_mode = 1;
	logic t1_esf = 0, tx_link_data, tx_link_clock, rx_link_clock;
	logic rx_link_data, msg_irq, h_ts, h_rs, h_rb;
	logic [4:0] cpu_addr = 0, ra[4] = '{5'h12, 5'h13, 5'h17, 5'h1e};
	logic [7:0] cpu_wdata = 0, cpu_rdata, rx_bits;
	logic [15:0] tw; // First message period seen on the line
	tdl_frame_t tx_frame = '0, rx_frame = '0;
	tdl_bp_t tx_bp = '0;
	tdl_oh_t tx_oh;
	int error_cnt = 0, tests_run = 0, cyc = 0, irqs = 0, hts = 0;
	logic hb = 1'b1; // Bit offered by controller zero
	logic [4:0] hch = 5'h01; // Controller zero channel select
	logic [31:0] rs = 32'h0000_0036; // Fixed seed
	always #5 clk_sys = ~clk_sys;
	tdl_link #(.SEC_COUNT(1000), .PAUSE_COUNT(100)) dut (.clk_sys(clk_sys),
		.reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.e1_mode(e1_mode), .t1_esf(t1_esf), .tx_frame(tx_frame),
		.tx_bp(tx_bp), .rx_frame(rx_frame), .tx_oh(tx_oh),
		.tx_link_clock(tx_link_clock), .tx_link_data(tx_link_data),
		.rx_link_clock(rx_link_clock), .rx_link_data(rx_link_data),
		.msg_irq(msg_irq), .hdlc_controller_zero_channel(hch), .hdlc_controller_zero_tx_bit(hb),
		.hdlc_controller_zero_tx_strobe(h_ts), .hdlc_controller_zero_rx_strobe(h_rs), .hdlc_controller_zero_rx_bit(h_rb));
	tdl_far_ctrl far (.tx_link_clock(tx_link_clock),
		.tx_link_data(tx_link_data), .rx_link_clock(rx_link_clock),
		.rx_link_data(rx_link_data), .rx_bits(rx_bits));
	// ====
	// Helpers: random source, compare, verdict
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard, well above the expected run; also counts interrupts
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (msg_irq === 1'b1) irqs <= irqs + 1;
		if (h_ts === 1'b1) hts <= hts + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	// ====
	// Bus and slot drivers, all on the falling edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{cpu_addr, cpu_wdata, cpu_wr} = {a, d, 1'b1};
		@(negedge clk_sys);
		cpu_wr = 0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		{cpu_addr, cpu_rd} = {a, 1'b1};
		@(negedge clk_sys);
		cpu_rd = 0;
		@(negedge clk_sys);
		chk(cpu_rdata, e);
	endtask
	// Backplane strobe, then measure the clock pulse it starts
	task automatic bp(input logic [2:0] i, input int e);
		int w;
		w = 0;
		@(negedge clk_sys);
		tx_bp = '{1'b1, i};
		@(negedge clk_sys);
		tx_bp = '0;
		while (tx_link_clock === 1'b1 && w < 40) begin
			@(negedge clk_sys);
			w++;
		end
		chk(8'(w), 8'(e));
		repeat (4) @(negedge clk_sys);
	endtask
	// Gap leaves room for a whole link clock pulse between slots
	task automatic slot(input tdl_frame_t f);
		repeat (28) @(negedge clk_sys);
		{tx_frame, rx_frame} = {f, f};
		@(negedge clk_sys);
		{tx_frame, rx_frame} = '0;
	endtask
	// Facility slots carrying the flag and a message, reps times
	task automatic msg(input logic [7:0] m, input int reps);
		logic [15:0] w;
		w = {MSG_FLAG, m};
		for (int k = 0; k < reps * 16; k++) begin
			slot('{1'b0, 3'd0, 1'b0, 1'b1, 1'b1, w[15 - k % 16]});
			if (k < 16) tw = {tw[14:0], tx_oh.value};
		end
	endtask
	// ====
	// Main sequence
	initial begin
		logic [7:0] v, er, tm, rm;
		logic [15:0] pq;
		logic b, s, e, hit;
		er = 0;
		pq = {far.PAT[15:12], 12'hfff}; // Only four bits fit in the FIFO
		repeat (4) @(negedge clk_sys);
		reset = 0;
		wr(5'h00, PAGE_CTRL);
		rd(5'h00, PAGE_CTRL);
		foreach (ra[j]) begin
			v = rs[7:0];
			rs = xs(rs);
			rd(ra[j], REG_RESET);
			wr(ra[j], v);
			rd(ra[j], v);
		end
		rd(5'h1a, 8'h00); // Unmapped place reads zero
		wr(5'h00, PAGE_STAT);
		wr(ADDR_RX_MSG, 8'hff);
		rd(ADDR_RX_MSG, 8'h00);
		wr(5'h00, PAGE_CTRL);
		wr(ADDR_LINK_CTRL, 8'h00);
		wr(ADDR_SPARE_SEL, 8'h05);
		wr(ADDR_IRQ_MASK3, 8'h02);
		bp(3'd7, 0);
		for (int k = 0; k < 5; k++) bp(3'(4 - k), k < 4 ? 24 : 0);
		// E1 spare slots: FIFO drains in order, then idles at one
		for (int k = 0; k < 15; k++) begin
			b = rs[0];
			rs = xs(rs);
			slot('{1'b1, 3'(k % 5), 1'b0, 1'b0, 1'b1, b});
			s = (k % 5 == 0) || (k % 5 == 2);
			e = 1'b0;
			if (s) e = pq[15];
			if (s) pq = {pq[14:0], 1'b1};
			chk({tx_oh.use_bit, tx_oh.value & s}, {s, e});
			chk({rx_link_clock, rx_link_data}, {s, b});
			if (s) er = {er[6:0], b};
		end
		chk({2'b00, rx_bits[5:0]}, er);
		// Controller zero on timeslot zero takes the selected spare bits
		hch = 5'h00;
		for (int k = 1; k < 3; k++) begin
			hb = rs[1];
			b = rs[0];
			rs = xs(rs);
			slot('{1'b1, 3'(k), 1'b0, 1'b0, 1'b1, b});
			s = (k == 2);
			chk({h_rs, h_rb & s, tx_oh.use_bit, tx_oh.value & s, rx_link_clock},
				{s, b & s, s, hb & s, 1'b0});
		end
		// T1 signaling frame slots, first with no link owner
		e1_mode = 0;
		slot('{1'b0, 3'd0, 1'b1, 1'b0, 1'b1, 1'b1});
		chk(tx_oh.use_bit, 1'b0);
		wr(ADDR_LINK_CTRL, 8'h80);
		slot('{1'b0, 3'd0, 1'b1, 1'b0, 1'b1, 1'b0});
		chk({tx_oh.use_bit, tx_link_clock, rx_link_clock}, 3'h7);
		// ESF messages both ways
		t1_esf = 1;
		tm = (rs[7:0] & 8'h7e) | 8'h02;
		rm = (rs[15:8] & 8'h7e) | 8'h04;
		rs = xs(rs);
		wr(ADDR_LINK_CTRL, 8'h40);
		wr(ADDR_TX_MSG, tm);
		msg(rm, 6);
		hit = 0;
		for (int r = 0; r < 16; r++)
			if (((tw << r) | (tw >> (16 - r))) === {MSG_FLAG, tm}) hit = 1;
		chk(hit, 1'b1);
		wr(5'h00, PAGE_STAT);
		rd(ADDR_RX_MSG, 8'h00);
		msg(rm, 4);
		rd(ADDR_RX_MSG, rm);
		chk(8'(irqs), 8'h01);
		wr(5'h00, PAGE_CTRL);
		wr(ADDR_IRQ_MASK3, 8'h00);
		msg(rm ^ 8'h18, 10);
		wr(5'h00, PAGE_STAT);
		rd(ADDR_RX_MSG, rm ^ 8'h18);
		chk(8'(irqs), 8'h01);
		// Controller zero on phantom channel 31 pauses the messages
		hch = 5'h1f;
		hb = rs[2];
		b = rs[3];
		rs = xs(rs);
		slot('{1'b0, 3'd0, 1'b0, 1'b1, 1'b1, b});
		chk({h_rs, h_rb, tx_oh.use_bit, tx_oh.value},
			{1'b1, b, 1'b1, hb});
		chk(8'(hts), 8'h02);
		end_sim();
	end
endmodule
